// ===== core/rcu_defs.svh
// Constants for the rotate-through-carry execution unit
`ifndef RCU_DEFS_SVH
`define RCU_DEFS_SVH

// Opcode bytes: count of one, count from count_low_register, immediate count
`define RCU_OP_BYTE_ONE   8'hd0
`define RCU_OP_BYTE_CNT   8'hd2
`define RCU_OP_BYTE_IMM   8'hc0
`define RCU_OP_WIDE_ONE   8'hd1
`define RCU_OP_WIDE_CNT   8'hd3
`define RCU_OP_WIDE_IMM   8'hc1

// Reg field of the addressing byte selecting the direction
`define RCU_SEL_LEFT      3'h2
`define RCU_SEL_RIGHT     3'h3

// Count masking keeps five bits
`define RCU_COUNT_BITS    5

// Cycle figures: single bit, multi-bit floor and ceiling, memory extra
`define RCU_CYC_ONE_REG   6'h03
`define RCU_CYC_ONE_MEM   6'h04
`define RCU_CYC_MULTI_MIN 6'h08
`define RCU_CYC_MULTI_MAX 6'h1e
`define RCU_CYC_MEM_EXTRA 6'h01

// Fault vectors
`define RCU_VEC_STACK     8'h0c
`define RCU_VEC_GENERAL   8'h0d
`define RCU_VEC_PAGE      8'h0e
`define RCU_VEC_ALIGN     8'h11
`define RCU_VEC_NONE      8'h00

// Bit positions in the flags word
`define RCU_BIT_CARRY     0
`define RCU_BIT_OVERFLOW  11

// Privilege level that enables alignment checking
`define RCU_PRIV_USER     2'h3

// Register map
`define RCU_ADDR_W        4
`define RCU_REG_CTRL      4'h0
`define RCU_REG_STATUS    4'h4
`define RCU_REG_RESULT    4'h8
`define RCU_CTRL_RESET    32'h0000_0001
`define RCU_CTRL_ENABLE   0
`define RCU_ST_BUSY       0
`define RCU_ST_FAULT      1
`define RCU_ST_VEC_LSB    8
`define RCU_ST_CARRY      16
`define RCU_ST_OVERFLOW   17

`endif

// ===== core/rcu_pkg.sv
// Types for the rotate-through-carry execution unit
package rcu_pkg;

  // Processor operating mode
  typedef enum logic [1:0] {
    MODE_REAL = 2'h0,
    MODE_PROT = 2'h1,
    MODE_V86  = 2'h2
  } mode_t;

  // Operand width
  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_WORD  = 2'h1,
    SIZE_DWORD = 2'h2
  } size_t;

  // Sequencer states, Gray coded along idle, run, finish
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RUN    = 2'b01,
    ST_FINISH = 2'b11
  } state_t;

  // Fault sources reported by the address and paging logic
  typedef struct packed {
    logic not_writable;
    logic bad_address;
    logic bad_stack;
    logic page_fail;
    logic unaligned;
    logic out_of_limit;
  } fault_src_t;

  // One instruction handed to the unit
  typedef struct packed {
    logic [7:0]  opcode;
    logic [2:0]  reg_field;
    logic [7:0]  immediate_count_byte;
    logic [7:0]  count_low_register;
    logic        opsize32;
    logic        is_mem;
    logic [31:0] operand;
    mode_t       mode;
    logic [1:0]  current_privilege_level;
    fault_src_t  faults;
  } rot_req_t;

  // Result of a rotation
  typedef struct packed {
    logic [31:0] value;
    logic        carry_flag;
    logic        overflow_flag;
  } rot_res_t;

endpackage

// ===== core/rotate_through_carry_unit.sv
// Rotate-through-carry execution datapath with sequencer and register port
// Operation
// - byte left rotate decodes three count forms
// - word/dword left rotate decodes three forms
// - byte right rotate decodes three count forms
// - word/dword right rotate decodes three forms
// - left step: msb to carry, carry in
// - right step: lsb to carry, carry in
// - count masked to low five bits
// - count from immediate or count_low_register
// - same masking in virtual 8086 mode
// - single left: overflow is msb xor carry
// - single right: overflow is top two differ
// - overflow undefined for other counts
// - carry holds last bit rotated out
// - sign, zero, aux, parity flags untouched
// - single bit: three reg, four memory
// - multi bit: 8-30 reg, 9-31 memory
// - protected mode faults 13, 12, 14
// - user level unaligned memory raises 17
// - real mode out of limit raises 13
`timescale 1ns/1ps
`include "rcu_defs.svh"
`default_nettype none

module rotate_through_carry_unit
  import rcu_pkg::*;
#(
  parameter int COUNT_BITS = `RCU_COUNT_BITS
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  input  wire logic                   i_ce,
  // Instruction request
  input  wire logic                   i_req_valid,
  input  var  rot_req_t               i_req,
  input  wire logic [31:0]            i_eflags,
  output logic                        o_busy,
  output logic                        o_reject,
  output logic                        o_done,
  output logic                        o_write_reg,
  output logic                        o_write_mem,
  output logic                        o_flags_we,
  output logic [31:0]                 o_result,
  output logic [31:0]                 o_eflags,
  output logic                        o_fault,
  output logic [7:0]                  o_fault_vec,
  // Register port
  input  wire logic [`RCU_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [31:0]                 o_rdata
);

  // Elaboration check: the count slice below is exactly five bits wide
  if (COUNT_BITS != `RCU_COUNT_BITS) begin
    $error("COUNT_BITS must be five");
  end

  // Reset image of the control word, a constant so that one bit can be picked
  localparam logic [31:0] CTRL_RESET_VALUE = `RCU_CTRL_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Rotation function

  // Rotates the operand with the carry n times within the given width
  function automatic rot_res_t rotate_n(input logic [31:0] op, input logic cin,
                                        input size_t sz, input logic right,
                                        input logic [4:0] n);
    rot_res_t    r;
    logic [31:0] v;
    logic        c;
    logic        msb;
    int          top;
    v   = op;
    c   = cin;
    top = (sz == SIZE_BYTE) ? 7 : ((sz == SIZE_WORD) ? 15 : 31);
    // Fixed trip count keeps the loop static; steps past n change nothing
    for (int i = 0; i < 31; i++) begin
      if (i < int'(n)) begin
        if (!right) begin
          msb = v[top];
          v   = {v[30:0], c};
          c   = msb;
        end else begin
          msb = v[0];
          v   = {1'b0, v[31:1]};
          v[top] = c;
          c   = msb;
        end
      end
    end
    // Left steps push stale bits above the width; clear them
    if (sz == SIZE_BYTE) begin
      v[31:8] = 24'h00_0000;
    end else if (sz == SIZE_WORD) begin
      v[31:16] = 16'h0000;
    end
    r.value      = v;
    r.carry_flag = c;
    // Overflow is only kept by the caller for a count of one
    if (!right) begin
      r.overflow_flag = v[top] ^ c;
    end else begin
      r.overflow_flag = v[top] ^ v[top-1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the incoming request

  logic       dec_known;
  logic       dec_right;
  size_t      dec_size;
  logic [7:0] dec_raw_count;
  logic [4:0] dec_count;
  logic [5:0] dec_cycles;
  logic [5:0] dec_multi;
  rot_res_t   dec_res;
  logic [7:0] dec_vec;

  // Opcode, direction, width and count source
  always_comb begin
    dec_known     = 1'b1;
    dec_size      = i_req.opsize32 ? SIZE_DWORD : SIZE_WORD;
    dec_raw_count = 8'h01;
    unique case (i_req.opcode)
      `RCU_OP_BYTE_ONE: begin
        dec_size = SIZE_BYTE;
      end
      `RCU_OP_BYTE_CNT: begin
        dec_size      = SIZE_BYTE;
        dec_raw_count = i_req.count_low_register;
      end
      `RCU_OP_BYTE_IMM: begin
        dec_size      = SIZE_BYTE;
        dec_raw_count = i_req.immediate_count_byte;
      end
      `RCU_OP_WIDE_ONE: begin
        dec_raw_count = 8'h01;
      end
      `RCU_OP_WIDE_CNT: begin
        dec_raw_count = i_req.count_low_register;
      end
      `RCU_OP_WIDE_IMM: begin
        dec_raw_count = i_req.immediate_count_byte;
      end
      default: begin
        dec_known = 1'b0;
      end
    endcase
    // Reg field selects the direction; any other value is an unknown request
    dec_right = (i_req.reg_field == `RCU_SEL_RIGHT);
    if ((i_req.reg_field != `RCU_SEL_LEFT) && !dec_right) begin
      dec_known = 1'b0;
    end
  end

  // Mask applies in every mode, virtual 8086 included
  assign dec_count = dec_raw_count[COUNT_BITS-1:0];

  // Cycle budget from the masked count and operand location
  always_comb begin
    dec_multi = (6'(dec_count) > (`RCU_CYC_MULTI_MIN + 6'h01)) ?
                (6'(dec_count) - 6'h01) : `RCU_CYC_MULTI_MIN;
    if (dec_multi > `RCU_CYC_MULTI_MAX) begin
      dec_multi = `RCU_CYC_MULTI_MAX;
    end
    if (dec_count <= 5'h01) begin
      dec_cycles = i_req.is_mem ? `RCU_CYC_ONE_MEM : `RCU_CYC_ONE_REG;
    end else begin
      dec_cycles = i_req.is_mem ? (dec_multi + `RCU_CYC_MEM_EXTRA)
                                : dec_multi;
    end
  end

  assign dec_res = rotate_n(i_req.operand, i_eflags[`RCU_BIT_CARRY], dec_size,
                            dec_right, dec_count);

  // Fault selection by mode, memory forms only
  always_comb begin
    dec_vec = `RCU_VEC_NONE;
    // Register forms touch no memory and so cannot fault
    if (i_req.is_mem) begin
      if (i_req.mode == MODE_REAL) begin
        if (i_req.faults.out_of_limit) begin
          dec_vec = `RCU_VEC_GENERAL;
        end
      end else begin
        // Protected and virtual 8086 modes share one priority order
        if (i_req.faults.not_writable || i_req.faults.bad_address) begin
          dec_vec = `RCU_VEC_GENERAL;
        end else if (i_req.faults.bad_stack) begin
          dec_vec = `RCU_VEC_STACK;
        end else if (i_req.faults.page_fail) begin
          dec_vec = `RCU_VEC_PAGE;
        end else if (i_req.faults.unaligned &&
                     (i_req.current_privilege_level == `RCU_PRIV_USER)) begin
          dec_vec = `RCU_VEC_ALIGN;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  state_t      state_reg;
  logic [5:0]  wait_reg;
  logic        enable_reg;
  logic        accept;
  logic        held_mem_reg;
  logic        held_flags_reg;
  logic [7:0]  held_vec_reg;
  logic [31:0] held_value_reg;
  logic [31:0] held_eflags_reg;

  // Accept needs an idle unit, enable set and a known encoding
  assign accept = i_ce && i_req_valid && (state_reg == ST_IDLE) &&
                  enable_reg && dec_known;

  // State and cycle counter
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      wait_reg  <= 6'h00;
    end else if (i_ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= ST_RUN;
            // Accept and finish edges are part of the budget
            wait_reg  <= dec_cycles - 6'h02;
          end
        end
        ST_RUN: begin
          if (wait_reg == 6'h00) begin
            state_reg <= ST_FINISH;
          end else begin
            wait_reg <= wait_reg - 6'h01;
          end
        end
        ST_FINISH: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Captured result, flags and fault of the accepted instruction
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      held_mem_reg    <= 1'b0;
      held_flags_reg  <= 1'b0;
      held_vec_reg    <= `RCU_VEC_NONE;
      held_value_reg  <= 32'h0000_0000;
      held_eflags_reg <= 32'h0000_0000;
    end else if (accept) begin
      held_mem_reg    <= i_req.is_mem;
      held_vec_reg    <= dec_vec;
      held_flags_reg  <= (dec_count != 5'h00);
      // A zero count still returns the operand cut to its width
      held_value_reg  <= dec_res.value;
      held_eflags_reg <= i_eflags;
      held_eflags_reg[`RCU_BIT_CARRY] <= dec_res.carry_flag;
      if (dec_count == 5'h01) begin
        held_eflags_reg[`RCU_BIT_OVERFLOW] <= dec_res.overflow_flag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  // Completion, write-back and fault reporting
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_done      <= 1'b0;
      o_write_reg <= 1'b0;
      o_write_mem <= 1'b0;
      o_flags_we  <= 1'b0;
      o_fault     <= 1'b0;
      o_fault_vec <= `RCU_VEC_NONE;
      o_result    <= 32'h0000_0000;
      o_eflags    <= 32'h0000_0000;
    end else if (i_ce) begin
      // Pulses drop by default and rise only in the finish state
      o_done      <= (state_reg == ST_FINISH);
      o_write_reg <= 1'b0;
      o_write_mem <= 1'b0;
      o_flags_we  <= 1'b0;
      o_fault     <= 1'b0;
      if (state_reg == ST_FINISH) begin
        o_result    <= held_value_reg;
        o_eflags    <= held_eflags_reg;
        o_fault_vec <= held_vec_reg;
        if (held_vec_reg != `RCU_VEC_NONE) begin
          o_fault <= 1'b1;
        end else begin
          o_write_mem <= held_mem_reg;
          o_write_reg <= !held_mem_reg;
          o_flags_we  <= held_flags_reg;
        end
      end
    end
  end

  // Busy and refusal indication
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_busy   <= 1'b0;
      o_reject <= 1'b0;
    end else if (i_ce) begin
      o_busy   <= accept || (state_reg == ST_RUN);
      // Only an idle unit refuses; a busy one ignores the request
      o_reject <= i_req_valid && (state_reg == ST_IDLE) &&
                  !(enable_reg && dec_known);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  // Control register write
  // Clearing enable refuses new requests; a running one still finishes
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      enable_reg <= CTRL_RESET_VALUE[`RCU_CTRL_ENABLE];
    end else if (i_ce && i_wr && (i_addr == `RCU_REG_CTRL)) begin
      enable_reg <= i_wdata[`RCU_CTRL_ENABLE];
    end
  end

  // Read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        unique case (i_addr)
          `RCU_REG_CTRL: begin
            o_rdata[`RCU_CTRL_ENABLE] <= enable_reg;
          end
          // Status mirrors the last accepted instruction, faulted or not
          `RCU_REG_STATUS: begin
            o_rdata[`RCU_ST_BUSY]     <= (state_reg != ST_IDLE);
            o_rdata[`RCU_ST_FAULT]    <= (held_vec_reg != `RCU_VEC_NONE);
            o_rdata[`RCU_ST_VEC_LSB +: 8] <= held_vec_reg;
            o_rdata[`RCU_ST_CARRY]    <= held_eflags_reg[`RCU_BIT_CARRY];
            o_rdata[`RCU_ST_OVERFLOW] <= held_eflags_reg[`RCU_BIT_OVERFLOW];
          end
          `RCU_REG_RESULT: begin
            o_rdata <= held_value_reg;
          end
          default: begin
            o_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== testbench/rotate_through_carry_unit_chk.sv
// Port-level assertions for the rotate-through-carry unit
`timescale 1ns/1ps
`include "rcu_defs.svh"
`default_nettype none
module rotate_through_carry_unit_chk
  import rcu_pkg::*;
#(
  parameter int COUNT_BITS = `RCU_COUNT_BITS
) (
  input wire logic                   i_mclk,
  input wire logic                   i_reset,
  input wire logic                   i_ce,
  input wire logic                   i_req_valid,
  input var  rot_req_t               i_req,
  input wire logic [31:0]            i_eflags,
  input wire logic                   o_busy,
  input wire logic                   o_reject,
  input wire logic                   o_done,
  input wire logic                   o_write_reg,
  input wire logic                   o_write_mem,
  input wire logic                   o_flags_we,
  input wire logic [31:0]            o_result,
  input wire logic [31:0]            o_eflags,
  input wire logic                   o_fault,
  input wire logic [7:0]             o_fault_vec,
  input wire logic [`RCU_ADDR_W-1:0] i_addr,
  input wire logic [31:0]            i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [31:0]            o_rdata
);
  logic [4:0]  n_c;
  logic [5:0]  t_c;
  logic        legal_c;
  logic        acc_c;
  logic        rej_c;
  logic        en_reg;
  logic        mem_reg;
  logic [5:0]  cnt_reg;
  logic [4:0]  n_reg;
  logic [31:0] fl_reg;

  // Masked count, expected latency and acceptance of the offered request
  always_comb begin
    case (i_req.opcode)
      `RCU_OP_BYTE_ONE, `RCU_OP_WIDE_ONE: n_c = 5'h01;
      `RCU_OP_BYTE_CNT, `RCU_OP_WIDE_CNT: n_c = i_req.count_low_register[4:0];
      default: n_c = i_req.immediate_count_byte[4:0];
    endcase
    if (n_c < 5'h02) t_c = 6'h03;
    else if (n_c < 5'h09) t_c = 6'h08;
    else t_c = {1'b0, n_c} - 6'h01;
    t_c = t_c + {5'h00, i_req.is_mem};
    legal_c = (i_req.opcode inside {8'hd0, 8'hd2, 8'hc0, 8'hd1, 8'hd3, 8'hc1})
              && (i_req.reg_field inside {`RCU_SEL_LEFT, `RCU_SEL_RIGHT});
    acc_c = i_ce && i_req_valid && !o_busy && en_reg && legal_c;
    rej_c = i_ce && i_req_valid && !o_busy && !(en_reg && legal_c);
  end

  // Shadow of the enable bit and a countdown to the expected completion
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      en_reg <= 1'b1;
      cnt_reg <= 6'h00;
    end else if (i_ce) begin
      if (i_wr && i_addr == `RCU_REG_CTRL) en_reg <= i_wdata[`RCU_CTRL_ENABLE];
      if (acc_c) cnt_reg <= t_c + 6'h01;  // Reads one in the done cycle
      else if (cnt_reg != 6'h00) cnt_reg <= cnt_reg - 6'h01;
    end
  end

  // Request details kept for the completion cycle
  always_ff @(posedge i_mclk) begin
    if (acc_c) begin
      n_reg <= n_c;
      fl_reg <= i_eflags;
      mem_reg <= i_req.is_mem;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_done_timing: assert property (o_done == (cnt_reg == 6'h01))
    else $error("completion not at the expected cycle");
  a_busy_span: assert property (o_busy == (cnt_reg > 6'h01))
    else $error("busy does not cover the operation");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_reject_code: assert property (i_ce && i_req_valid && !o_busy |=> o_reject == $past(rej_c))
    else $error("reject does not match the decode");
  a_fault_quiet: assert property (o_fault |-> o_done && !o_write_reg && !o_write_mem && !o_flags_we)
    else $error("faulting operation still writes");
  a_write_target: assert property (o_done && !o_fault |-> o_write_mem == mem_reg && o_write_reg == !mem_reg)
    else $error("write goes to the wrong place");
  a_flags_gate: assert property (o_done |-> o_flags_we == (!o_fault && n_reg != 5'h00))
    else $error("flag write enable wrong");
  a_flags_keep: assert property (o_done |-> o_eflags[31:12] == fl_reg[31:12] && o_eflags[10:1] == fl_reg[10:1])
    else $error("untouched flags changed");
  a_vec_code: assert property (o_done |-> (o_fault ? (o_fault_vec inside {8'h0c, 8'h0d, 8'h0e, 8'h11}) : o_fault_vec == 8'h00))
    else $error("fault vector out of set");
  a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
    else $error("read data without a read");
endmodule
`default_nettype wire

// ===== testbench/rotate_through_carry_unit_tb.sv
// Self-checking bench for the rotate-through-carry unit
`timescale 1ns/1ps
`include "rcu_defs.svh"
`default_nettype none
module rotate_through_carry_unit_tb
  import rcu_pkg::*;
;
  logic        i_mclk, i_reset, i_ce, i_req_valid, i_wr, i_rd;
  rot_req_t    i_req;
  logic [31:0] i_eflags, i_wdata, o_result, o_eflags, o_rdata;
  logic [3:0]  i_addr;
  logic        o_busy, o_reject, o_done, o_write_reg, o_write_mem, o_flags_we, o_fault;
  logic [7:0]  o_fault_vec;
  int          num_errors, n_compared, stall_cycles;

  rotate_through_carry_unit rotate_through_carry_unit_inst (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_eflags(i_eflags), .o_busy(o_busy), .o_reject(o_reject),
    .o_done(o_done), .o_write_reg(o_write_reg), .o_write_mem(o_write_mem),
    .o_flags_we(o_flags_we), .o_result(o_result), .o_eflags(o_eflags), .o_fault(o_fault),
    .o_fault_vec(o_fault_vec), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata));

  // 25 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic tally_and_finish;
    $display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Register port strobes, one cycle each
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference: masked count, fault vector and the rotation itself
  function automatic int cnt_of(input rot_req_t r);
    case (r.opcode)
      `RCU_OP_BYTE_ONE, `RCU_OP_WIDE_ONE: return 1;
      `RCU_OP_BYTE_CNT, `RCU_OP_WIDE_CNT: return int'(r.count_low_register[4:0]);
      default: return int'(r.immediate_count_byte[4:0]);
    endcase
  endfunction

  function automatic logic [7:0] vec_of(input rot_req_t r);
    fault_src_t f;
    f = r.faults;
    if (r.mode == MODE_REAL) return f.out_of_limit ? 8'h0d : 8'h00;
    if (f.not_writable || f.bad_address) return 8'h0d;
    if (f.bad_stack) return 8'h0c;
    if (f.page_fail) return 8'h0e;
    if (r.current_privilege_level == 2'h3 && f.unaligned) return 8'h11;
    return 8'h00;
  endfunction

  function automatic rot_res_t model(input rot_req_t r, input logic cin);
    rot_res_t    e;
    logic [31:0] m;
    logic        t;
    int          w;
    w = (r.opcode inside {8'hd0, 8'hd2, 8'hc0}) ? 8 : (r.opsize32 ? 32 : 16);
    m = (w == 32) ? 32'hffffffff : (32'h1 << w) - 32'h1;
    e.value = r.operand & m;
    for (int i = 0; i < cnt_of(r); i++) begin
      if (r.reg_field == `RCU_SEL_LEFT) begin
        t = e.value[w-1];
        e.value = ((e.value << 1) | cin) & m;
      end else begin
        t = e.value[0];
        e.value = (e.value >> 1) | ({31'h0, cin} << (w - 1));
      end
      cin = t;
    end
    e.carry_flag = cin;
    if (r.reg_field == `RCU_SEL_LEFT) e.overflow_flag = e.value[w-1] ^ cin;
    else e.overflow_flag = e.value[w-1] ^ e.value[w-2];
    return e;
  endfunction

  function automatic rot_req_t rnd_req(input logic [7:0] op, input logic [2:0] rf, input logic mem);
    rot_req_t    r;
    logic [95:0] b;
    b = {$urandom, $urandom, $urandom};
    r = b[$bits(rot_req_t)-1:0];
    r.opcode = op;
    r.reg_field = rf;
    r.is_mem = mem;
    r.mode = mode_t'($urandom_range(2));
    if ($urandom_range(1) == 1) r.faults = '0;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One accepted request, then latency, outputs and flags compared
  task automatic run_op(input rot_req_t r, input logic [31:0] fl);
    rot_res_t    e;
    logic [31:0] ef;
    logic [7:0]  v;
    logic [31:0] d;
    int          n, t, cyc;
    e = model(r, fl[0]);
    n = cnt_of(r);
    t = ((n < 2) ? 3 : ((n < 9) ? 8 : n - 1)) + r.is_mem;
    v = r.is_mem ? vec_of(r) : 8'h00;
    ef = fl;
    ef[0] = e.carry_flag;
    if (n == 1) ef[11] = e.overflow_flag;
    @(posedge i_mclk);
    i_req <= r;
    i_eflags <= fl;
    i_req_valid <= 1'b1;
    @(posedge i_mclk);
    i_req_valid <= 1'b0;
    // Clock enable held low freezes the unit for the stall span
    repeat (stall_cycles) begin
      i_ce <= 1'b0;
      @(posedge i_mclk);
    end
    i_ce <= 1'b1;
    cyc = 0;
    do begin
      @(posedge i_mclk);
      #1 cyc++;
    end while (o_done !== 1'b1 && cyc < 40);
    chk("latency", t, cyc);
    chk("fault_vec", v, o_fault_vec);
    chk("fault", v != 8'h00, o_fault);
    if (v == 8'h00) begin
      chk("result", e.value, o_result);
      chk("eflags", ef, o_eflags);
      chk("writes", {r.is_mem, !r.is_mem, n != 0}, {o_write_mem, o_write_reg, o_flags_we});
    end
    reg_rd(`RCU_REG_RESULT, d);
    chk("result_reg", e.value, d);
    reg_rd(`RCU_REG_STATUS, d);
    chk("status_reg", {14'h0, ef[11], ef[0], v, 6'h0, v != 8'h00, 1'b0}, d);
  endtask

  // Refused request: one-cycle reject and no operation
  task automatic rej(input rot_req_t r);
    @(posedge i_mclk);
    i_req <= r;
    i_req_valid <= 1'b1;
    @(posedge i_mclk);
    i_req_valid <= 1'b0;
    #1 chk("reject", 1'b1, o_reject);
    chk("busy", 1'b0, o_busy);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    rot_req_t    r;
    logic [7:0]  ops[6] = '{8'hd0, 8'hd2, 8'hc0, 8'hd1, 8'hd3, 8'hc1};
    logic [7:0]  cn[9] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'h0a, 8'h1f, 8'h20, 8'h21, 8'hff};
    {i_reset, i_ce, i_req_valid, i_wr, i_rd} = 5'b11000;
    i_req = '0;
    {i_eflags, i_wdata, i_addr} = '0;
    d = $urandom(32'h09c0b604);
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    reg_rd(`RCU_REG_CTRL, d);
    chk("ctrl", `RCU_CTRL_RESET, d);
    reg_wr(4'hc, 32'hffffffff);
    reg_rd(4'hc, d);
    chk("unmapped", 32'h0, d);
    $display("test registers done");
    for (int k = 0; k < 96; k++) begin
      r = rnd_req(ops[k % 6], (k % 12 < 6) ? `RCU_SEL_LEFT : `RCU_SEL_RIGHT, k[4]);
      stall_cycles = k % 4;
      run_op(r, $urandom);
    end
    stall_cycles = 0;
    $display("test random done");
    foreach (cn[j]) begin
      r = rnd_req(`RCU_OP_WIDE_CNT, j[0] ? `RCU_SEL_RIGHT : `RCU_SEL_LEFT, 1'b0);
      r.mode = MODE_V86;
      r.count_low_register = cn[j];
      run_op(r, $urandom);
      r.opcode = `RCU_OP_BYTE_IMM;
      r.immediate_count_byte = cn[j];
      run_op(r, $urandom);
    end
    $display("test counts done");
    for (int f = 0; f < 18; f++) begin
      r = rnd_req(`RCU_OP_BYTE_ONE, `RCU_SEL_LEFT, 1'b1);
      r.faults = fault_src_t'(6'h01 << (f % 6));
      r.mode = (f < 12) ? MODE_PROT : MODE_REAL;
      r.current_privilege_level = (f < 6) ? 2'h3 : 2'h0;
      run_op(r, $urandom);
    end
    $display("test faults done");
    rej(rnd_req(8'h90, `RCU_SEL_LEFT, 1'b0));
    r = rnd_req(`RCU_OP_WIDE_ONE, 3'h5, 1'b0);
    rej(r);
    reg_wr(`RCU_REG_CTRL, 32'h0);
    r.reg_field = `RCU_SEL_LEFT;
    rej(r);
    // Reset of the idle unit with enable cleared restores the enable bit
    @(posedge i_mclk);
    i_reset <= 1'b1;
    @(posedge i_mclk);
    i_reset <= 1'b0;
    reg_rd(`RCU_REG_CTRL, d);
    chk("ctrl_reset", `RCU_CTRL_RESET, d);
    reg_wr(`RCU_REG_CTRL, `RCU_CTRL_RESET);
    run_op(r, $urandom);
    $display("test refusals done");
    tally_and_finish;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    tally_and_finish;
  end
endmodule

bind rotate_through_carry_unit rotate_through_carry_unit_chk #(.COUNT_BITS(COUNT_BITS))
  rotate_through_carry_unit_chk_inst (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_req_valid(i_req_valid),
  .i_req(i_req), .i_eflags(i_eflags), .o_busy(o_busy), .o_reject(o_reject),
  .o_done(o_done), .o_write_reg(o_write_reg), .o_write_mem(o_write_mem),
  .o_flags_we(o_flags_we), .o_result(o_result), .o_eflags(o_eflags), .o_fault(o_fault),
  .o_fault_vec(o_fault_vec), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata));
`default_nettype wire
